// File: gepb_bridge.sv
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "gepb_params.svh"
// Function
// - byte-wide port exists only when the gigabit variant is selected; the ports always exist and USE_GMII only gates port_on.
// - link bytes move only at frame slots from the control-word pointer onward.
// - status bits: 3 empty, 2 almost empty, 1 full, 0 almost full.
// - receive valid high for packet data or the start character.
// - receive error high forces receive byte to 0x0E.
// - receive byte zero in reset, all ones until frame sync.
// - receive and transmit data buses are eight bits wide.
// - transmit reset clears transmit port and fifo write logic.
// - start character is inserted during the two-cycle enable lead.
// - falling transmit enable inserts terminate then carrier characters.
// - transmit error replaces outgoing data with the error symbol.
// - transmit byte, enable and error are sampled on transmit clock rise.
module gepb_bridge #(
  parameter bit USE_GMII = 1'b1
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // byte port toward the external mac
  input  wire logic        gmii_txclk,
  input  wire logic        gmii_txreset_n,
  input  wire logic        gmii_txen,
  input  wire logic        gmii_txer,
  input  wire logic [7:0]  gmii_txd,
  input  wire logic        gmii_rxclk,
  input  wire logic        gmii_rxreset_n,
  output logic      [7:0]  gmii_rxd,
  output logic             gmii_rxdv,
  output logic             gmii_rxer,
  output logic      [3:0]  gmii_txfifo_status,
  output logic      [3:0]  gmii_rxfifo_status,
  // link framer side
  input  wire logic        link_frame_sync,
  input  wire logic        link_cw_strobe,
  input  wire logic [5:0]  link_cw_index,
  input  wire logic        link_rx_valid,
  input  wire logic        link_rx_k,
  input  wire logic [7:0]  link_rx_data,
  output logic             link_tx_valid,
  output logic             link_tx_k,
  output logic      [7:0]  link_tx_data,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq
);

  gepb_pkg::gepb_state_type st_r;
  gepb_pkg::gepb_state_type st_nxt;
  gepb_pkg::gepb_pins_type  pins;

  logic                    tx_edge;
  logic                    rx_edge;
  logic                    port_on;
  logic                    slot;
  logic [`GEPB_FIFO_AW:0]  tx_cnt;
  logic [`GEPB_FIFO_AW:0]  rx_cnt;
  logic [`GEPB_FIFO_AW-1:0] tx_last;

  // ****************************************
  // pin sampling and edge finding
  // ****************************************
  // all pins are gathered so they share one two-stage synchroniser
  assign pins    = '{txclk: gmii_txclk, txen: gmii_txen, txer: gmii_txer, txd: gmii_txd,
                     txrst_n: gmii_txreset_n, rxclk: gmii_rxclk, rxrst_n: gmii_rxreset_n};
  // data is taken from the stage behind the clock so it is the value from before the edge
  assign tx_edge = st_r.ps.txclk & ~st_r.pp.txclk;
  assign rx_edge = st_r.ps.rxclk & ~st_r.pp.rxclk;
  assign port_on = USE_GMII & st_r.ctrl_en;
  assign tx_cnt  = st_r.txwp - st_r.txrp;
  assign rx_cnt  = st_r.rxwp - st_r.rxrp;
  assign tx_last = st_r.txwp[`GEPB_FIFO_AW-1:0] - 4'h1;
  // the framer sweeps the control words; ours start at the pointer
  assign slot    = port_on & link_cw_strobe & (st_r.ptr != 6'h00) & (link_cw_index >= st_r.ptr);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [4:0]  ev;
    logic [4:0]  clr;
    gepb_pkg::gepb_entry_type e;
    ev     = 5'h00;
    clr    = 5'h00;
    e      = st_r.rxmem[st_r.rxrp[`GEPB_FIFO_AW-1:0]];
    st_nxt = st_r;
    st_nxt.pm = pins;
    st_nxt.ps = st_r.pm;
    st_nxt.pp = st_r.ps;
    st_nxt.link_tx_valid = 1'b0;

    // transmit framing, one step per port clock edge
    if (!st_r.ps.txrst_n) begin
      st_nxt.tx_state = gepb_pkg::GEPB_TX_IDLE;
      st_nxt.txwp     = st_r.txrp;
    end else if (tx_edge && port_on) begin
      case (st_r.tx_state)
        gepb_pkg::GEPB_TX_IDLE: begin
          if (st_r.pp.txen) begin
            e = '{k: 1'b1, data: `GEPB_K_START};
            st_nxt.tx_state = gepb_pkg::GEPB_TX_LEAD;
          end
        end
        gepb_pkg::GEPB_TX_LEAD: begin
          // second lead cycle carries nothing; the start symbol already went in
          if (st_r.pp.txen) begin
            st_nxt.tx_state = gepb_pkg::GEPB_TX_DATA;
          end else begin
            e = '{k: 1'b1, data: `GEPB_K_TERM};
            st_nxt.tx_state = gepb_pkg::GEPB_TX_TERM;
          end
        end
        gepb_pkg::GEPB_TX_DATA: begin
          if (!st_r.pp.txen) begin
            e = '{k: 1'b1, data: `GEPB_K_TERM};
            st_nxt.tx_state = gepb_pkg::GEPB_TX_TERM;
          end else if (st_r.pp.txer) begin
            e = '{k: 1'b1, data: `GEPB_K_ERROR};
          end else begin
            e = '{k: 1'b0, data: st_r.pp.txd};
          end
        end
        gepb_pkg::GEPB_TX_TERM: begin
          e = '{k: 1'b1, data: `GEPB_K_CARRIER};
          st_nxt.tx_state = gepb_pkg::GEPB_TX_IDLE;
        end
        default: begin
          st_nxt.tx_state = gepb_pkg::GEPB_TX_IDLE;
        end
      endcase
      // an entry is pushed whenever the step above produced a symbol
      if ((st_r.tx_state != gepb_pkg::GEPB_TX_LEAD || !st_r.pp.txen) &&
          (st_r.tx_state != gepb_pkg::GEPB_TX_IDLE || st_r.pp.txen)) begin
        if (tx_cnt != `GEPB_FIFO_DEPTH) begin
          st_nxt.txmem[st_r.txwp[`GEPB_FIFO_AW-1:0]] = e;
          st_nxt.txwp = st_r.txwp + 5'h01;
        end else begin
          ev[`GEPB_IRQ_TXOVF] = 1'b1; // dropped: the mac ignored full
        end
      end
    end

    // link side drains the transmit fifo at its own slots
    if (slot && tx_cnt != 5'h00 && st_r.ps.txrst_n) begin
      st_nxt.link_tx_valid = 1'b1;
      st_nxt.link_tx_k     = st_r.txmem[st_r.txrp[`GEPB_FIFO_AW-1:0]].k;
      st_nxt.link_tx_data  = st_r.txmem[st_r.txrp[`GEPB_FIFO_AW-1:0]].data;
      st_nxt.txrp          = st_r.txrp + 5'h01;
    end

    // link side fills the receive fifo at the same slots
    if (slot && link_rx_valid) begin
      if (rx_cnt != `GEPB_FIFO_DEPTH) begin
        st_nxt.rxmem[st_r.rxwp[`GEPB_FIFO_AW-1:0]] = '{k: link_rx_k, data: link_rx_data};
        st_nxt.rxwp = st_r.rxwp + 5'h01;
      end else begin
        ev[`GEPB_IRQ_RXOVF] = 1'b1;
      end
    end

    // receive port output, one byte per port clock edge
    e = st_r.rxmem[st_r.rxrp[`GEPB_FIFO_AW-1:0]];
    if (!st_r.ps.rxrst_n) begin
      st_nxt.rxrp      = st_r.rxwp;
      st_nxt.rxd       = 8'h00;
      st_nxt.rxdv      = 1'b0;
      st_nxt.rxer      = 1'b0;
      st_nxt.rx_in_pkt = 1'b0;
    end else if (!link_frame_sync) begin
      st_nxt.rxd       = `GEPB_RX_NOSYNC;
      st_nxt.rxdv      = 1'b0;
      st_nxt.rxer      = 1'b0;
      st_nxt.rx_in_pkt = 1'b0;
    end else if (rx_edge) begin
      if (rx_cnt == 5'h00) begin
        // starving mid-packet is reported as an error byte, not silence
        st_nxt.rxdv      = st_r.rx_in_pkt;
        st_nxt.rxer      = st_r.rx_in_pkt;
        st_nxt.rxd       = st_r.rx_in_pkt ? `GEPB_RX_ERR_BYTE : 8'h00;
        ev[`GEPB_IRQ_RXUNF] = st_r.rx_in_pkt;
        st_nxt.rx_in_pkt = 1'b0;
      end else begin
        st_nxt.rxrp = st_r.rxrp + 5'h01;
        st_nxt.rxer = 1'b0;
        if (e.k && e.data == `GEPB_K_ERROR) begin
          st_nxt.rxdv = 1'b1;
          st_nxt.rxer = 1'b1;
          st_nxt.rxd  = `GEPB_RX_ERR_BYTE;
        end else if (e.k && e.data == `GEPB_K_START) begin
          st_nxt.rxdv      = 1'b1;
          st_nxt.rxd       = e.data;
          st_nxt.rx_in_pkt = 1'b1;
        end else if (e.k) begin
          st_nxt.rxdv      = 1'b0;
          st_nxt.rxd       = 8'h00;
          st_nxt.rx_in_pkt = 1'b0;
        end else begin
          st_nxt.rxdv = 1'b1;
          st_nxt.rxd  = e.data;
        end
      end
    end

    // frame sync transitions
    st_nxt.sync_d = link_frame_sync;
    ev[`GEPB_IRQ_SYNCUP] = link_frame_sync & ~st_r.sync_d;
    ev[`GEPB_IRQ_SYNCDN] = ~link_frame_sync & st_r.sync_d;

    // axi write: address and data may come in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wstrb0 = s_axi_wstrb[0];
    end
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = `GEPB_RESP_OKAY;
      case (st_r.awaddr)
        `GEPB_ADDR_CTRL: if (st_r.wstrb0) st_nxt.ctrl_en = st_r.wdata[0];
        `GEPB_ADDR_PTR: if (st_r.wstrb0) st_nxt.ptr = st_r.wdata[5:0];
        `GEPB_ADDR_IRQ_STAT: if (st_r.wstrb0) clr = st_r.wdata[4:0];
        `GEPB_ADDR_IRQ_MASK: if (st_r.wstrb0) st_nxt.irq_mask = st_r.wdata[4:0];
        `GEPB_ADDR_STATUS: begin
        end
        default: st_nxt.bresp = `GEPB_RESP_SLVERR;
      endcase
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
    st_nxt.wready  = ~st_nxt.w_got & ~st_nxt.bvalid;

    // axi read: one outstanding, data one cycle after the address
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rresp   = `GEPB_RESP_OKAY;
      st_nxt.rdata   = 32'h0000_0000;
      case (s_axi_araddr)
        `GEPB_ADDR_CTRL: st_nxt.rdata[0] = st_r.ctrl_en;
        `GEPB_ADDR_PTR: st_nxt.rdata[5:0] = st_r.ptr;
        `GEPB_ADDR_STATUS: begin
          st_nxt.rdata[3:0] = st_r.txfs;
          st_nxt.rdata[`GEPB_STAT_RXFS_LSB+:4] = st_r.rxfs;
          st_nxt.rdata[`GEPB_STAT_SYNC_BIT] = st_r.sync_d;
        end
        `GEPB_ADDR_IRQ_STAT: st_nxt.rdata[4:0] = st_r.irq_status;
        `GEPB_ADDR_IRQ_MASK: st_nxt.rdata[4:0] = st_r.irq_mask;
        default: st_nxt.rresp = `GEPB_RESP_SLVERR;
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end

    // sticky events: a set in the clearing cycle survives
    st_nxt.irq_status = (st_r.irq_status & ~clr) | ev;
    st_nxt.irq        = |(st_nxt.irq_status & st_nxt.irq_mask);

    // fifo status from the pointers that will hold next cycle
    st_nxt.txfs[`GEPB_FS_EMPTY]  = (st_nxt.txwp - st_nxt.txrp) == 5'h00;
    st_nxt.txfs[`GEPB_FS_AEMPTY] = (st_nxt.txwp - st_nxt.txrp) <= `GEPB_FIFO_AE;
    st_nxt.txfs[`GEPB_FS_FULL]   = (st_nxt.txwp - st_nxt.txrp) == `GEPB_FIFO_DEPTH;
    st_nxt.txfs[`GEPB_FS_AFULL]  = (st_nxt.txwp - st_nxt.txrp) >= `GEPB_FIFO_AF;
    st_nxt.rxfs[`GEPB_FS_EMPTY]  = (st_nxt.rxwp - st_nxt.rxrp) == 5'h00;
    st_nxt.rxfs[`GEPB_FS_AEMPTY] = (st_nxt.rxwp - st_nxt.rxrp) <= `GEPB_FIFO_AE;
    st_nxt.rxfs[`GEPB_FS_FULL]   = (st_nxt.rxwp - st_nxt.rxrp) == `GEPB_FIFO_DEPTH;
    st_nxt.rxfs[`GEPB_FS_AFULL]  = (st_nxt.rxwp - st_nxt.rxrp) >= `GEPB_FIFO_AF;
  end

  // ****************************************
  // state register
  // ****************************************
  // the reset image keeps the port resets asserted until the pins say otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r            <= '0;
      st_r.awready    <= 1'b1;
      st_r.wready     <= 1'b1;
      st_r.arready    <= 1'b1;
      st_r.ctrl_en    <= `GEPB_CTRL_RST;
      st_r.ptr        <= `GEPB_PTR_RST;
      st_r.irq_mask   <= `GEPB_MASK_RST;
      st_r.txfs       <= 4'hC;
      st_r.rxfs       <= 4'hC;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign gmii_rxd           = st_r.rxd;
  assign gmii_rxdv          = st_r.rxdv;
  assign gmii_rxer          = st_r.rxer;
  assign gmii_txfifo_status = st_r.txfs;
  assign gmii_rxfifo_status = st_r.rxfs;
  assign link_tx_valid      = st_r.link_tx_valid;
  assign link_tx_k          = st_r.link_tx_k;
  assign link_tx_data       = st_r.link_tx_data;
  assign s_axi_awready      = st_r.awready;
  assign s_axi_wready       = st_r.wready;
  assign s_axi_bvalid       = st_r.bvalid;
  assign s_axi_bresp        = st_r.bresp;
  assign s_axi_arready      = st_r.arready;
  assign s_axi_rvalid       = st_r.rvalid;
  assign s_axi_rdata        = st_r.rdata;
  assign s_axi_rresp        = st_r.rresp;
  assign irq                = st_r.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rx_err_byte: assert property (
    gmii_rxer |-> gmii_rxd == `GEPB_RX_ERR_BYTE) else $error("rx error without 0x0E byte");
  a_rx_in_reset: assert property (
    (ce && !st_r.ps.rxrst_n) |=> gmii_rxd == 8'h00 && !gmii_rxdv) else $error("rx byte not low in reset");
  a_rx_nosync: assert property (
    (ce && st_r.ps.rxrst_n && !link_frame_sync) |=> gmii_rxd == `GEPB_RX_NOSYNC) else $error("rx byte not ones");
  a_rx_data_valid: assert property (
    (ce && st_r.ps.rxrst_n && link_frame_sync && rx_edge && rx_cnt != 5'h00 && !e_k_now())
    |=> gmii_rxdv && gmii_rxd == $past(st_r.rxmem[st_r.rxrp[`GEPB_FIFO_AW-1:0]].data))
    else $error("rx data byte not presented as valid");
  a_tx_start_sym: assert property (
    (ce && st_r.ps.txrst_n && port_on && tx_edge && st_r.pp.txen && tx_cnt < 5'h0F &&
     st_r.tx_state == gepb_pkg::GEPB_TX_IDLE)
    |=> st_r.txmem[tx_last].data == `GEPB_K_START && st_r.tx_state == gepb_pkg::GEPB_TX_LEAD)
    else $error("start symbol not inserted");
  a_tx_term_sym: assert property (
    (ce && st_r.ps.txrst_n && port_on && tx_edge && !st_r.pp.txen && tx_cnt < 5'h0F &&
     st_r.tx_state == gepb_pkg::GEPB_TX_DATA)
    |=> st_r.txmem[tx_last].data == `GEPB_K_TERM && st_r.tx_state == gepb_pkg::GEPB_TX_TERM)
    else $error("terminate symbol not inserted");
  a_tx_err_sym: assert property (
    (ce && st_r.ps.txrst_n && port_on && tx_edge && st_r.pp.txen && st_r.pp.txer && tx_cnt < 5'h0F &&
     st_r.tx_state == gepb_pkg::GEPB_TX_DATA)
    |=> st_r.txmem[tx_last] == {1'b1, `GEPB_K_ERROR}) else $error("error symbol not inserted");
  a_tx_reset_idle: assert property (
    (ce && !st_r.ps.txrst_n) |=> st_r.tx_state == gepb_pkg::GEPB_TX_IDLE) else $error("tx not idle in reset");
  a_fifo_empty_bit: assert property (
    $past(ce) |-> gmii_txfifo_status[`GEPB_FS_EMPTY] == (tx_cnt == 5'h00)) else $error("tx empty bit wrong");
  a_slot_pop: assert property (
    (ce && slot && tx_cnt != 5'h00 && st_r.ps.txrst_n) |=> link_tx_valid &&
    (tx_cnt == $past(tx_cnt) - 5'h01 || (tx_cnt == $past(tx_cnt) && $past(tx_edge))))
    else $error("slot did not take a byte");

  function automatic logic e_k_now();
    e_k_now = st_r.rxmem[st_r.rxrp[`GEPB_FIFO_AW-1:0]].k;
  endfunction
endmodule

// File: gepb_params.svh
`ifndef GEPB_PARAMS_SVH
`define GEPB_PARAMS_SVH
// ****************************************
// register map (byte addresses, one word each)
// ****************************************
`define GEPB_ADDR_CTRL      8'h00
`define GEPB_ADDR_PTR       8'h04
`define GEPB_ADDR_STATUS    8'h08
`define GEPB_ADDR_IRQ_STAT  8'h0C
`define GEPB_ADDR_IRQ_MASK  8'h10
`define GEPB_CTRL_RST       1'h1
`define GEPB_PTR_RST        6'h14
`define GEPB_MASK_RST       5'h00
`define GEPB_STAT_RXFS_LSB  4
`define GEPB_STAT_SYNC_BIT  8
`define GEPB_RESP_OKAY      2'h0
`define GEPB_RESP_SLVERR    2'h2
// ****************************************
// fifo geometry and status bit positions
// ****************************************
`define GEPB_FIFO_AW        4
`define GEPB_FIFO_DEPTH     5'h10
`define GEPB_FIFO_AE        5'h02
`define GEPB_FIFO_AF        5'h0E
`define GEPB_FS_EMPTY       3
`define GEPB_FS_AEMPTY      2
`define GEPB_FS_FULL        1
`define GEPB_FS_AFULL       0
// ****************************************
// symbols and interrupt bits
// ****************************************
`define GEPB_K_START        8'hFB
`define GEPB_K_TERM         8'hFD
`define GEPB_K_CARRIER      8'hF7
`define GEPB_K_ERROR        8'hFE
`define GEPB_RX_ERR_BYTE    8'h0E
`define GEPB_RX_NOSYNC      8'hFF
`define GEPB_IRQ_TXOVF      0
`define GEPB_IRQ_RXOVF      1
`define GEPB_IRQ_RXUNF      2
`define GEPB_IRQ_SYNCUP     3
`define GEPB_IRQ_SYNCDN     4
`endif

// File: gepb_pkg.sv
`include "gepb_params.svh"
package gepb_pkg;
  typedef enum logic [1:0] {
    GEPB_TX_IDLE = 2'b00,
    GEPB_TX_LEAD = 2'b01,
    GEPB_TX_DATA = 2'b10,
    GEPB_TX_TERM = 2'b11
  } gepb_tx_state_type;

  typedef struct packed {
    logic       k;
    logic [7:0] data;
  } gepb_entry_type;

  typedef struct packed {
    logic       txclk;
    logic       txen;
    logic       txer;
    logic [7:0] txd;
    logic       txrst_n;
    logic       rxclk;
    logic       rxrst_n;
  } gepb_pins_type;

  typedef struct packed {
    gepb_pins_type                                pm;
    gepb_pins_type                                ps;
    gepb_pins_type                                pp;
    gepb_tx_state_type                            tx_state;
    gepb_entry_type [`GEPB_FIFO_DEPTH-5'h01:0]    txmem;
    gepb_entry_type [`GEPB_FIFO_DEPTH-5'h01:0]    rxmem;
    logic [`GEPB_FIFO_AW:0]                       txwp;
    logic [`GEPB_FIFO_AW:0]                       txrp;
    logic [`GEPB_FIFO_AW:0]                       rxwp;
    logic [`GEPB_FIFO_AW:0]                       rxrp;
    logic [7:0]                                   rxd;
    logic                                         rxdv;
    logic                                         rxer;
    logic                                         rx_in_pkt;
    logic [3:0]                                   txfs;
    logic [3:0]                                   rxfs;
    logic [7:0]                                   link_tx_data;
    logic                                         link_tx_k;
    logic                                         link_tx_valid;
    logic                                         awready;
    logic                                         wready;
    logic                                         bvalid;
    logic [1:0]                                   bresp;
    logic                                         arready;
    logic                                         rvalid;
    logic [31:0]                                  rdata;
    logic [1:0]                                   rresp;
    logic                                         aw_got;
    logic                                         w_got;
    logic [7:0]                                   awaddr;
    logic [31:0]                                  wdata;
    logic                                         wstrb0;
    logic                                         ctrl_en;
    logic [5:0]                                   ptr;
    logic [4:0]                                   irq_status;
    logic [4:0]                                   irq_mask;
    logic                                         irq;
    logic                                         sync_d;
  } gepb_state_type;
endpackage

// File: gepb_mac_model.sv
`timescale 1ns/1ps
// ****************************************
// external mac stand-in for the byte port
// ****************************************
module gepb_mac_model (
  // transmit side
  output logic       txclk,
  output logic       txen,
  output logic       txer,
  output logic [7:0] txd,
  // receive side
  output logic       rxclk
);
  // port clocks stand still outside frames
  initial begin
    {txclk, rxclk, txen, txer} = 4'h0;
    txd = 8'h00;
  end
  // one 64 ns tx clock period, rising edge half way
  task automatic tick();
    #32 txclk = 1'b1;
    #32 txclk = 1'b0;
  endtask
  // mac pulls a byte on every call, whether or not the fifo holds one
  task automatic rx_tick();
    #32 rxclk = 1'b1;
    #32 rxclk = 1'b0;
  endtask
  // enable leads the first byte by two edges; byte number bad carries the error flag
  task automatic send(input logic [31:0] f, input int bad);
    txen = 1'b1;
    tick();
    tick();
    for (int i = 0; i < 4; i++) begin
      txd = f[31-8*i -: 8];
      txer = (i == bad);
      tick();
    end
    txen = 1'b0;
    txer = 1'b0;
    txd = ~txd; // idle bus must not look like the last byte
    tick();
    tick();
  endtask
endmodule

// File: gepb_bridge_tb.sv
`timescale 1ns/1ps
`include "gepb_params.svh"
module gepb_bridge_tb;
  // ****************************************
  // signals
  // ****************************************
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, link_frame_sync = 1'b0, gmii_txreset_n = 1'b0;
  logic        gmii_rxreset_n = 1'b0, link_cw_strobe = 1'b0, link_rx_valid = 1'b0, link_rx_k = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, gmii_txclk, gmii_txen, gmii_txer, gmii_rxclk, gmii_rxdv, gmii_rxer, irq;
  logic        link_tx_valid, link_tx_k, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [5:0]  link_cw_index = 6'h14;
  logic [7:0]  link_rx_data = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, gmii_txd, gmii_rxd, link_tx_data;
  logic [3:0]  s_axi_wstrb = 4'hF, gmii_txfifo_status, gmii_rxfifo_status;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, ph = 2'h0;
  logic [8:0]  txq[$], rxq[$];
  int          err_total = 0, compares = 0;

  gepb_bridge DUT (.aclk, .aresetn, .ce, .gmii_txclk, .gmii_txreset_n, .gmii_txen, .gmii_txer, .gmii_txd,
    .gmii_rxclk, .gmii_rxreset_n, .gmii_rxd, .gmii_rxdv, .gmii_rxer, .gmii_txfifo_status, .gmii_rxfifo_status,
    .link_frame_sync, .link_cw_strobe, .link_cw_index, .link_rx_valid, .link_rx_k, .link_rx_data,
    .link_tx_valid, .link_tx_k, .link_tx_data, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  gepb_mac_model u_mac (.txclk(gmii_txclk), .txen(gmii_txen), .txer(gmii_txer), .txd(gmii_txd), .rxclk(gmii_rxclk));

  // 200 MHz core clock
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // a slot every fourth cycle; queued link bytes ride on slots, link output is collected
  always @(posedge aclk) begin
    ph <= ph + 2'h1;
    link_cw_strobe <= (ph == 2'h0);
    link_rx_valid <= 1'b0;
    if (ph == 2'h0 && rxq.size() > 0) begin
      {link_rx_k, link_rx_data} <= rxq.pop_front();
      link_rx_valid <= 1'b1;
    end
    if (link_tx_valid === 1'b1) txq.push_back({link_tx_k, link_tx_data});
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic lim(input int n);
    if (n >= 100) begin
      err_total++;
      $display("[ERR] %0t bus handshake timed out", $time);
      wrap_up();
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    {n, aw, w} = {32'd0, 2'b11};
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while ((aw || w) && n < 100) begin
      @(posedge aclk);
      n++;
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin @(posedge aclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 100);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    lim(n);
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 100);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 100);
    {rd, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    lim(n);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic sc_reset();
    repeat (6) @(posedge aclk);
    chk(gmii_rxd, 8'h00);
    chk({gmii_txfifo_status, gmii_rxfifo_status}, 8'hCC);
    {aresetn, gmii_txreset_n, gmii_rxreset_n} <= 3'b111;
    repeat (8) @(posedge aclk);
    chk(gmii_rxd, `GEPB_RX_NOSYNC);
    gmii_rxreset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    chk({gmii_rxdv, gmii_rxer, gmii_rxd}, 10'h000);
    gmii_rxreset_n <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(gmii_rxd, `GEPB_RX_NOSYNC);
  endtask
  task automatic sc_regs();
    axr(`GEPB_ADDR_PTR);
    chk(rd, 32'h14);
    chk(resp, `GEPB_RESP_OKAY);
    axr(8'h40);
    chk(resp, `GEPB_RESP_SLVERR);
    chk(rd, 32'h0);
    axw(8'h40, 32'hFF);
    chk(resp, `GEPB_RESP_SLVERR);
  endtask
  // frame with an error on its third byte; link sees start, data, error, end symbols
  // then a frame sent while the port is disabled must not reach the link at all
  task automatic sc_tx();
    logic [8:0] e[7];
    e = '{9'h1FB, 9'h011, 9'h022, 9'h1FE, 9'h044, 9'h1FD, 9'h1F7};
    u_mac.send(32'h11223344, 2);
    repeat (60) @(posedge aclk);
    chk(txq.size(), 7);
    for (int i = 0; i < 7; i++) chk(txq[i], e[i]);
    chk(gmii_txfifo_status, 4'hC);
    axw(`GEPB_ADDR_CTRL, 32'h0);
    u_mac.send(32'h55667788, 9);
    repeat (20) @(posedge aclk);
    chk(txq.size(), 7);
    chk(gmii_txfifo_status, 4'hC);
    axw(`GEPB_ADDR_CTRL, 32'h1);
  endtask
  // link bytes reach the port; sync gain raises a masked-in interrupt, cleared by a write of one
  task automatic sc_rx();
    logic [9:0] e[5];
    e = '{10'h2FB, 10'h255, 10'h30E, 10'h000, 10'h000};
    axw(`GEPB_ADDR_IRQ_MASK, 32'h8);
    link_frame_sync <= 1'b1;
    rxq = '{9'h1FB, 9'h055, 9'h1FE, 9'h1FD};
    repeat (40) @(posedge aclk);
    chk({irq, gmii_rxfifo_status}, 5'h10);
    for (int i = 0; i < 5; i++) begin
      u_mac.rx_tick();
      repeat (4) @(posedge aclk);
      chk({gmii_rxdv, gmii_rxer, gmii_rxd}, e[i]);
    end
    chk(gmii_rxfifo_status, 4'hC);
    axw(`GEPB_ADDR_IRQ_STAT, 32'h8);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
  endtask

  // bounded run
  initial begin
    #200000;
    err_total++;
    $display("[ERR] %0t run timed out", $time);
    wrap_up();
  end
  initial begin
    sc_reset();
    sc_regs();
    sc_tx();
    sc_rx();
    wrap_up();
  end
endmodule
